// File: core/rcr_defines.svh
// Register addresses, field positions and reset values of the respiration control registers.
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH
`define RCR_ADDR_ONE 8'h09
`define RCR_ADDR_TWO 8'h0a
`define RCR_RESET_ONE 8'h02
`define RCR_RESET_TWO 8'h03
`define RCR_READ_NONE 8'h00
`define RCR_BIT_DEMOD 7
`define RCR_BIT_MOD 6
`define RCR_PH_HI 5
`define RCR_PH_LO 2
`define RCR_BIT_CMODE 0
`define RCR_BIT_CAL 7
`define RCR_BIT_FREQ 2
`define RCR_BIT_LEGREF 1
`define RCR_PH_TOP 3
`define RCR_PHASE_RESET 4'h0
`endif

// File: core/rcr_pkg.sv
// Types shared by the respiration control register bank.
`default_nettype none
package rcr_pkg;
    typedef logic [7:0] rcr_byte_t;
    typedef logic [3:0] rcr_phase_t;
    typedef struct packed {
        logic demodulator_enable;
        logic modulator_enable;
        rcr_phase_t demod_phase_code;
        rcr_phase_t phase_steps;
        logic resp_clock_mode;
        logic resp_clock_rate;
        logic offset_cal_enable;
        logic leg_drive_ref_internal;
    } rcr_ctrl_s;
endpackage : rcr_pkg
`default_nettype wire

// File: core/rcr_regs.sv
// Respiration control register bank with decoded control outputs.
//
// Behaviour
// RULE1 - Bit 7 of register one turns channel 1 demodulator on; reset off.
// RULE2 - Bit 6 of register one turns channel 1 modulator on; reset off.
// RULE3 - Bits 5:2 set demodulation phase, 11.25 degree steps at 32 kHz; reset 0000.
// RULE4 - At 64 kHz the top phase bit is ignored; 22.5 degree steps.
// RULE5 - Bit 0 of register one selects internal or external respiration clock.
// RULE6 - Bit 7 of register two enables offset calibration; reset disabled.
// RULE7 - With internal clock, bit 2 of register two picks 32 or 64 kHz.
// RULE8 - Software writes 1 to frequency select on parts lacking respiration.
// RULE9 - Bit 1 of register two selects internal leg drive reference; reset internal.
// RULE10 - Register one sits at address 09h, register two at 0Ah.
// RULE11 - Software keeps the fixed-value bits of both registers at their set values.
// RULE12 - A read returns the last written value of both registers.
`timescale 1ns/1ns
`default_nettype none
`include "rcr_defines.svh"
module rcr_regs (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_RD,
    output logic [7:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    output var rcr_pkg::rcr_ctrl_s O_CTRL
);
    rcr_pkg::rcr_byte_t resp_one_r;
    rcr_pkg::rcr_byte_t resp_two_r;
    rcr_pkg::rcr_byte_t resp_one_nxt;
    rcr_pkg::rcr_byte_t resp_two_nxt;
    rcr_pkg::rcr_byte_t rdata_r;
    logic rvalid_r;
    rcr_pkg::rcr_ctrl_s ctrl_r;

    // Decodes a register pair into the control outputs.
    function automatic rcr_pkg::rcr_ctrl_s decode(input rcr_pkg::rcr_byte_t one,
                                                  input rcr_pkg::rcr_byte_t two);
        rcr_pkg::rcr_ctrl_s c;
        logic rate64;
        rate64 = (one[`RCR_BIT_CMODE] == 1'b0) && two[`RCR_BIT_FREQ]; // RULE7
        c.demodulator_enable = one[`RCR_BIT_DEMOD]; // RULE1
        c.modulator_enable = one[`RCR_BIT_MOD]; // RULE2
        c.demod_phase_code = one[`RCR_PH_HI:`RCR_PH_LO]; // RULE3
        c.phase_steps = rate64 ? {one[`RCR_PH_HI-1:`RCR_PH_LO], 1'b0}
                               : one[`RCR_PH_HI:`RCR_PH_LO]; // RULE4
        c.resp_clock_mode = one[`RCR_BIT_CMODE]; // RULE5
        c.resp_clock_rate = rate64; // RULE7
        c.offset_cal_enable = two[`RCR_BIT_CAL]; // RULE6
        c.leg_drive_ref_internal = two[`RCR_BIT_LEGREF]; // RULE9
        return c;
    endfunction : decode

    // Next register values from the write port.
    always_comb begin
        resp_one_nxt = resp_one_r;
        resp_two_nxt = resp_two_r;
        if (I_REG_WR && I_REG_ADDR == `RCR_ADDR_ONE) begin // RULE10
            resp_one_nxt = I_REG_WDATA; // RULE12
        end
        if (I_REG_WR && I_REG_ADDR == `RCR_ADDR_TWO) begin // RULE10
            resp_two_nxt = I_REG_WDATA; // RULE12
        end
    end

    // Register one storage.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            resp_one_r <= `RCR_RESET_ONE;
        end else begin
            resp_one_r <= resp_one_nxt;
        end
    end

    // Register two storage.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            resp_two_r <= `RCR_RESET_TWO;
        end else begin
            resp_two_r <= resp_two_nxt;
        end
    end

    // Control outputs track the stored registers in the same cycle.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ctrl_r <= decode(`RCR_RESET_ONE, `RCR_RESET_TWO);
        end else begin
            ctrl_r <= decode(resp_one_nxt, resp_two_nxt);
        end
    end

    // Read port answers one cycle after the request; unmapped addresses read zero.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            rdata_r <= `RCR_READ_NONE;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= I_REG_RD;
            if (!I_REG_RD) begin
                rdata_r <= `RCR_READ_NONE;
            end else if (I_REG_ADDR == `RCR_ADDR_ONE) begin
                rdata_r <= resp_one_r; // RULE12
            end else if (I_REG_ADDR == `RCR_ADDR_TWO) begin
                rdata_r <= resp_two_r; // RULE12
            end else begin
                rdata_r <= `RCR_READ_NONE;
            end
        end
    end

    assign O_REG_RDATA = rdata_r;
    assign O_REG_RVALID = rvalid_r;
    assign O_CTRL = ctrl_r;

    sequence s_wr_one;
        I_REG_WR && I_REG_ADDR == `RCR_ADDR_ONE && !I_RESET;
    endsequence
    sequence s_wr_two;
        I_REG_WR && I_REG_ADDR == `RCR_ADDR_TWO && !I_RESET;
    endsequence
    sequence s_rd_one;
        I_REG_RD && !I_REG_WR && I_REG_ADDR == `RCR_ADDR_ONE;
    endsequence
    sequence s_rd_two;
        I_REG_RD && !I_REG_WR && I_REG_ADDR == `RCR_ADDR_TWO;
    endsequence

    AST_DEMOD_FOLLOWS: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE1
        s_wr_one |=> O_CTRL.demodulator_enable == $past(I_REG_WDATA[`RCR_BIT_DEMOD]))
        else $error("Demodulator enable does not follow its write bit.");

    AST_MOD_FOLLOWS: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE2
        s_wr_one |=> O_CTRL.modulator_enable == $past(I_REG_WDATA[`RCR_BIT_MOD]))
        else $error("Modulator enable does not follow its write bit.");

    AST_PHASE_FOLLOWS: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE3
        s_wr_one |=> O_CTRL.demod_phase_code == $past(I_REG_WDATA[`RCR_PH_HI:`RCR_PH_LO]))
        else $error("Phase code does not follow its write field.");

    AST_RESET_OFF: assert property (@(posedge I_CLK) // RULE3
        I_RESET |=> O_CTRL.demod_phase_code == `RCR_PHASE_RESET && !O_CTRL.demodulator_enable
            && !O_CTRL.modulator_enable && !O_CTRL.offset_cal_enable
            && O_CTRL.leg_drive_ref_internal && !O_CTRL.resp_clock_rate)
        else $error("Reset values wrong.");

    AST_RESET_MODE: assert property (@(posedge I_CLK) // RULE5
        I_RESET |=> !O_CTRL.resp_clock_mode && O_CTRL.phase_steps == `RCR_PHASE_RESET)
        else $error("Clock mode or phase steps wrong after reset.");

    AST_RESET_READ: assert property (@(posedge I_CLK) // RULE12
        I_RESET |=> !O_REG_RVALID && O_REG_RDATA == `RCR_READ_NONE)
        else $error("Read port not idle after reset.");

    AST_PHASE_64K: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE4
        O_CTRL.resp_clock_rate |-> O_CTRL.phase_steps
            == {O_CTRL.demod_phase_code[`RCR_PH_TOP-1:0], 1'b0})
        else $error("Phase steps wrong at 64 kHz.");

    AST_PHASE_32K: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE3
        !O_CTRL.resp_clock_rate |-> O_CTRL.phase_steps == O_CTRL.demod_phase_code)
        else $error("Phase steps wrong at 32 kHz.");

    AST_MODE_FOLLOWS: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE5
        s_wr_one |=> O_CTRL.resp_clock_mode == $past(I_REG_WDATA[`RCR_BIT_CMODE]))
        else $error("Clock mode does not follow its write bit.");

    AST_RATE_EXTERNAL: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE7
        s_wr_one ##0 I_REG_WDATA[`RCR_BIT_CMODE] |=> !O_CTRL.resp_clock_rate)
        else $error("64 kHz kept after external clock mode was written.");

    AST_CAL_FOLLOWS: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE6
        s_wr_two |=> O_CTRL.offset_cal_enable == $past(I_REG_WDATA[`RCR_BIT_CAL]))
        else $error("Calibration enable does not follow its write bit.");

    AST_RATE_RULE: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE7
        O_CTRL.resp_clock_rate |-> !O_CTRL.resp_clock_mode)
        else $error("64 kHz selected with external clock mode.");

    AST_RATE_FOLLOWS: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE7
        s_wr_two |=> O_CTRL.resp_clock_rate
            == (!$past(O_CTRL.resp_clock_mode) && $past(I_REG_WDATA[`RCR_BIT_FREQ])))
        else $error("Clock rate does not follow frequency select and mode.");

    AST_LEGREF_FOLLOWS: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE9
        s_wr_two |=> O_CTRL.leg_drive_ref_internal == $past(I_REG_WDATA[`RCR_BIT_LEGREF]))
        else $error("Leg drive reference does not follow its write bit.");

    AST_READBACK: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE12
        s_wr_two ##1 s_rd_two
            |=> O_REG_RVALID && O_REG_RDATA == $past(I_REG_WDATA, 2))
        else $error("Read does not return last written value.");

    AST_READBACK_ONE: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE12
        s_wr_one ##1 s_rd_one
            |=> O_REG_RVALID && O_REG_RDATA == $past(I_REG_WDATA, 2))
        else $error("Register one read does not return last written value.");

    AST_READ_ONE_MATCH: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE12
        s_rd_one |=> O_REG_RDATA[`RCR_BIT_DEMOD] == $past(O_CTRL.demodulator_enable)
            && O_REG_RDATA[`RCR_BIT_MOD] == $past(O_CTRL.modulator_enable)
            && O_REG_RDATA[`RCR_PH_HI:`RCR_PH_LO] == $past(O_CTRL.demod_phase_code)
            && O_REG_RDATA[`RCR_BIT_CMODE] == $past(O_CTRL.resp_clock_mode))
        else $error("Register one read disagrees with its control outputs.");

    AST_READ_TWO_MATCH: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE12
        s_rd_two |=> O_REG_RDATA[`RCR_BIT_CAL] == $past(O_CTRL.offset_cal_enable)
            && O_REG_RDATA[`RCR_BIT_LEGREF] == $past(O_CTRL.leg_drive_ref_internal))
        else $error("Register two read disagrees with its control outputs.");

    AST_RVALID_FOLLOWS: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE12
        I_REG_RD |=> O_REG_RVALID)
        else $error("Read request not answered in the next cycle.");

    AST_RDATA_IDLE: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE12
        !I_REG_RD |=> !O_REG_RVALID && O_REG_RDATA == `RCR_READ_NONE)
        else $error("Read port not idle without a request.");

    AST_CTRL_HOLD: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE12
        !I_REG_WR |=> $stable(O_CTRL))
        else $error("Control outputs changed without a write.");

    AST_WR_IGNORED: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE10
        I_REG_WR && I_REG_ADDR != `RCR_ADDR_ONE && I_REG_ADDR != `RCR_ADDR_TWO
            |=> $stable(O_CTRL))
        else $error("Unmapped write changed the control outputs.");

    AST_UNMAPPED: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE10
        I_REG_RD && I_REG_ADDR != `RCR_ADDR_ONE && I_REG_ADDR != `RCR_ADDR_TWO
            |=> O_REG_RVALID && O_REG_RDATA == `RCR_READ_NONE)
        else $error("Unmapped read not zero.");
endmodule : rcr_regs
`default_nettype wire

// File: tb/test_rcr_regs.sv
// Self-checking testbench for the respiration control register bank.
`timescale 1ns/1ns
`default_nettype none
module test_rcr_regs;
    logic I_CLK = 1'b0;
    logic I_RESET = 1'b1;
    logic [7:0] I_REG_ADDR = 8'h00;
    logic I_REG_WR = 1'b0;
    logic [7:0] I_REG_WDATA = 8'h00;
    logic I_REG_RD = 1'b0;
    logic [7:0] O_REG_RDATA;
    logic O_REG_RVALID;
    rcr_pkg::rcr_ctrl_s O_CTRL;
    logic [7:0] one_r = 8'h02;
    logic [7:0] two_r = 8'h03;
    int fails = 0;
    int comparisons = 0;
    rcr_regs rcr_regs_i (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_REG_ADDR(I_REG_ADDR),
        .I_REG_WR(I_REG_WR), .I_REG_WDATA(I_REG_WDATA), .I_REG_RD(I_REG_RD),
        .O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID), .O_CTRL(O_CTRL));
    initial begin
        forever #4 I_CLK = ~I_CLK;
    end
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Expected control outputs from the shadow copies of both registers.
    function automatic rcr_pkg::rcr_ctrl_s expc();
        rcr_pkg::rcr_ctrl_s c;
        c.demodulator_enable = one_r[7];
        c.modulator_enable = one_r[6];
        c.demod_phase_code = one_r[5:2];
        c.resp_clock_mode = one_r[0];
        c.resp_clock_rate = !one_r[0] && two_r[2];
        c.phase_steps = c.resp_clock_rate ? {one_r[4:2], 1'b0} : one_r[5:2];
        c.offset_cal_enable = two_r[7];
        c.leg_drive_ref_internal = two_r[1];
        return c;
    endfunction : expc
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge I_CLK);
        I_REG_ADDR = addr;
        I_REG_WDATA = data;
        I_REG_WR = 1'b1;
        @(negedge I_CLK);
        I_REG_WR = 1'b0;
        if (addr == 8'h09) one_r = data;
        if (addr == 8'h0a) two_r = data;
        chk("control outputs", {2'b0, expc()}, {2'b0, O_CTRL});
    endtask : wr
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge I_CLK);
        I_REG_ADDR = addr;
        I_REG_RD = 1'b1;
        @(negedge I_CLK);
        I_REG_RD = 1'b0;
        chk("read valid", 16'h0001, {15'h0, O_REG_RVALID});
        chk("read data", {8'h0, exp}, {8'h0, O_REG_RDATA});
        @(negedge I_CLK);
        chk("read idle", 16'h0000, {7'h0, O_REG_RVALID, O_REG_RDATA});
    endtask : rd
    task automatic wr_rd(input logic [7:0] addr, input logic [7:0] data, input logic [7:0] old);
        @(negedge I_CLK);
        I_REG_ADDR = addr;
        I_REG_WDATA = data;
        I_REG_WR = 1'b1;
        I_REG_RD = 1'b1;
        @(negedge I_CLK);
        I_REG_WR = 1'b0;
        chk("read during write", {8'h0, old}, {8'h0, O_REG_RDATA});
        @(negedge I_CLK);
        I_REG_RD = 1'b0;
        chk("read after write", {8'h0, data}, {8'h0, O_REG_RDATA});
        if (addr == 8'h09) one_r = data;
        if (addr == 8'h0a) two_r = data;
        chk("control outputs", {2'b0, expc()}, {2'b0, O_CTRL});
    endtask : wr_rd
    initial begin
        repeat (4) @(negedge I_CLK);
        I_RESET = 1'b0;
        chk("reset controls", {2'b0, expc()}, {2'b0, O_CTRL});
        rd(8'h09, 8'h02);
        rd(8'h0a, 8'h03);
        wr(8'h09, 8'hc4);
        for (int f = 0; f < 2; f++) begin
            wr(8'h0a, f[0] ? 8'h07 : 8'h03);
            for (int c = 0; c < 16; c++) begin
                wr(8'h09, {2'b11, c[3:0], 2'b10});
                rd(8'h09, {2'b11, c[3:0], 2'b10});
            end
        end
        wr(8'h09, 8'h3f);
        wr(8'h0a, 8'h81);
        rd(8'h0a, 8'h81);
        wr(8'h0b, 8'h55);
        rd(8'h0b, 8'h00);
        rd(8'h09, 8'h3f);
        wr_rd(8'h0a, 8'h05, 8'h81);
        wr_rd(8'h09, 8'h2a, 8'h3f);
        @(negedge I_CLK);
        I_RESET = 1'b1;
        repeat (4) @(negedge I_CLK);
        I_RESET = 1'b0;
        one_r = 8'h02;
        two_r = 8'h03;
        chk("reset controls", {2'b0, expc()}, {2'b0, O_CTRL});
        rd(8'h09, 8'h02);
        rd(8'h0a, 8'h03);
        print_verdict();
    end
    initial begin
        repeat (2000) @(posedge I_CLK);
        fails++;
        print_verdict();
    end
endmodule : test_rcr_regs
`default_nettype wire
